// File: pkg/ddr_bank_defs.svh
`ifndef DDR_BANK_DEFS_SVH
`define DDR_BANK_DEFS_SVH
`define CLK_PERIOD_NS 100
`define T_RP_NS 15
`define RP_CYC ((`T_RP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_RAS_NS 40
`define RAS_CYC ((`T_RAS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_RFC_NS 70
`define RFC_CYC ((`T_RFC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_XSNR_NS 75
`define XSNR_CYC ((`T_XSNR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define XSRD_CYC 200
`define T_REFI_NS 7800
`define REFI_CYC (`T_REFI_NS / `CLK_PERIOD_NS)
`define MAX_POSTED 8
`define BURST_CYC 2
`define A10_BIT 10
`define ADDR_W 13
`define ROW_CNT_W 13
`endif

// File: pkg/ddr_bank_pkg.sv
package ddr_bank_pkg;
  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRE, CMD_REF, CMD_SREF,
    CMD_EMRS_DLL
  } cmd_e;
  typedef enum logic [1:0] {
    BANK_IDLE, BANK_ACTIVE, BANK_PRECHARGING
  } bank_e;
  typedef enum logic [2:0] {
    DEV_NORMAL, DEV_REFRESH, DEV_SELF_REFRESH, DEV_PRE_PD, DEV_ACT_PD
  } dev_e;
  typedef logic [7:0] cnt_t;
endpackage

// File: pkg/ddr_link_if.sv
`timescale 1ns/1ps
interface ddr_link_if;
  logic cke;
  ddr_bank_pkg::cmd_e cmd;
  logic [1:0] ba;
  logic [12:0] addr;
  modport ctrl (output cke, output cmd, output ba, output addr);
  modport dram (input cke, input cmd, input ba, input addr);
endinterface

// File: src/ddr_bank_dev.sv
`timescale 1ns/1ps
`include "ddr_bank_defs.svh"
// Behaviour
// - Activation waits precharge time after PRECHARGE
// - A10 high precharges all, else BA bank
// - Precharged bank idle; activate before access
// - PRECHARGE to idle/precharging bank is NOP
// - Other-bank access allowed during auto precharge
// - A10 on READ/WRITE auto precharges bank
// - Auto precharge waits for row-active minimum
// - No command to bank until precharge done
// - Refresh rows come from internal counter
// - Refresh each interval, at most eight posted; REF only on request, interval and posted count not tracked
// - CKE high throughout refresh period
// - Only NOP during refresh; banks precharged first
// - Self refresh: DLL off, inputs except CKE ignored
// - Self refresh entry only with all idle
// - NOP only for exit time after self refresh
// - DLL reset and 200 cycles before READ
// - Self refresh re-entry after full refresh
// - Frequency change in self refresh needs DLL reset
// - CKE high until access completes
// - CKE low enters precharge or active power-down
// - Power-down disables buffers, freezes DLL if idle
// - CKE high with NOP exits power-down
module ddr_bank_dev (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Link
  ddr_link_if.dram link,
  // Status
  output logic [7:0] bank_state,
  output ddr_bank_pkg::dev_e dev_state,
  output logic dll_on,
  output logic buffers_on,
  output logic cmd_ok,
  output logic [12:0] refresh_row
);
  import ddr_bank_pkg::*;

  bank_e bank_ff [4];
  bank_e nxt_bank [4];
  cnt_t tmr_ff [4];
  cnt_t nxt_tmr [4];
  cnt_t ras_ff [4];
  cnt_t nxt_ras [4];
  logic [3:0] ap_ff;
  logic [3:0] nxt_ap;
  dev_e dev_ff;
  dev_e nxt_dev;
  cnt_t dev_tmr_ff;
  cnt_t nxt_dev_tmr;
  logic [12:0] row_ff;
  logic dll_ff;
  logic ok_ff;

  wire cke = link.cke;
  wire cmd_e cmd = link.cmd;
  wire a10 = link.addr[`A10_BIT];
  wire is_nop = (cmd == CMD_NOP);
  wire normal = (dev_ff == DEV_NORMAL);
  wire any_open = (bank_ff[0] == BANK_ACTIVE) | (bank_ff[1] == BANK_ACTIVE)
    | (bank_ff[2] == BANK_ACTIVE) | (bank_ff[3] == BANK_ACTIVE);
  wire all_idle = (bank_ff[0] == BANK_IDLE) & (bank_ff[1] == BANK_IDLE)
    & (bank_ff[2] == BANK_IDLE) & (bank_ff[3] == BANK_IDLE);

  function automatic cnt_t dec(input cnt_t v);
    dec = (v == 8'h00) ? 8'h00 : v - 8'h01;
  endfunction

  always_comb begin
    nxt_dev = dev_ff;
    nxt_dev_tmr = dec(dev_tmr_ff);
    for (int b = 0; b < 4; b++) begin
      nxt_bank[b] = bank_ff[b];
      nxt_tmr[b] = dec(tmr_ff[b]);
      nxt_ras[b] = dec(ras_ff[b]);
      nxt_ap[b] = ap_ff[b];
      if (bank_ff[b] == BANK_PRECHARGING && tmr_ff[b] <= 8'h01)
        nxt_bank[b] = BANK_IDLE;
      if (bank_ff[b] == BANK_ACTIVE && ap_ff[b] && ras_ff[b] <= 8'h01
          && tmr_ff[b] <= 8'h01) begin
        nxt_bank[b] = BANK_PRECHARGING;
        nxt_tmr[b] = cnt_t'(`RP_CYC);
        nxt_ap[b] = 1'b0;
      end
    end
    case (dev_ff)
      DEV_NORMAL: begin
        if (!cke) begin
          // Self refresh is the SREF code registered with CKE low and all banks idle
          if (cmd == CMD_SREF && all_idle)
            nxt_dev = DEV_SELF_REFRESH;
          else
            nxt_dev = any_open ? DEV_ACT_PD : DEV_PRE_PD;
        end else begin
          case (cmd)
            CMD_ACT: begin
              if (bank_ff[link.ba] == BANK_IDLE) begin
                nxt_bank[link.ba] = BANK_ACTIVE;
                nxt_ras[link.ba] = cnt_t'(`RAS_CYC);
              end
            end
            CMD_READ, CMD_WRITE: begin
              if (bank_ff[link.ba] == BANK_ACTIVE && a10) begin
                nxt_ap[link.ba] = 1'b1;
                nxt_tmr[link.ba] = cnt_t'(`BURST_CYC);
              end
            end
            CMD_PRE: begin
              for (int b = 0; b < 4; b++) begin
                if ((a10 || link.ba == b[1:0])
                    && bank_ff[b] == BANK_ACTIVE) begin
                  nxt_bank[b] = BANK_PRECHARGING;
                  nxt_tmr[b] = cnt_t'(`RP_CYC);
                  nxt_ap[b] = 1'b0;
                end
              end
            end
            CMD_REF: begin
              nxt_dev = DEV_REFRESH;
              nxt_dev_tmr = cnt_t'(`RFC_CYC);
            end
            default: begin
            end
          endcase
        end
      end
      DEV_REFRESH: begin
        if (dev_tmr_ff <= 8'h01)
          nxt_dev = DEV_NORMAL;
      end
      DEV_SELF_REFRESH: begin
        if (cke) begin
          nxt_dev = DEV_NORMAL;
        end
      end
      DEV_PRE_PD, DEV_ACT_PD: begin
        if (cke && is_nop)
          nxt_dev = DEV_NORMAL;
      end
      default: nxt_dev = DEV_NORMAL;
    endcase
  end

  // Refresh row advances once per command, so posted refreshes stay in order
  wire row_step = normal && cke && cmd == CMD_REF;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int b = 0; b < 4; b++) begin
        bank_ff[b] <= BANK_IDLE;
        tmr_ff[b] <= 8'h00;
        ras_ff[b] <= 8'h00;
      end
      ap_ff <= 4'h0;
      dev_ff <= DEV_NORMAL;
      dev_tmr_ff <= 8'h00;
      row_ff <= 13'h0000;
      dll_ff <= 1'b1;
      ok_ff <= 1'b0;
    end else begin
      for (int b = 0; b < 4; b++) begin
        bank_ff[b] <= nxt_bank[b];
        tmr_ff[b] <= nxt_tmr[b];
        ras_ff[b] <= nxt_ras[b];
      end
      ap_ff <= nxt_ap;
      dev_ff <= nxt_dev;
      dev_tmr_ff <= nxt_dev_tmr;
      if (row_step)
        row_ff <= row_ff + 13'h0001;
      dll_ff <= !(nxt_dev == DEV_SELF_REFRESH
        || nxt_dev == DEV_PRE_PD);
      ok_ff <= (nxt_dev == DEV_NORMAL);
    end
  end

  always_comb begin
    for (int b = 0; b < 4; b++)
      bank_state[2*b +: 2] = bank_ff[b];
  end
  assign dev_state = dev_ff;
  assign dll_on = dll_ff;
  assign buffers_on = ok_ff;
  assign cmd_ok = ok_ff;
  assign refresh_row = row_ff;
endmodule

// File: src/ddr_bank_ctrl.sv
`timescale 1ns/1ps
`include "ddr_bank_defs.svh"
module ddr_bank_ctrl (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // User request
  input wire logic req_valid,
  input wire ddr_bank_pkg::cmd_e req_cmd,
  input wire logic [1:0] req_ba,
  input wire logic [12:0] req_addr,
  input wire logic req_cke,
  output logic req_ready,
  // Link
  ddr_link_if.ctrl link
);
  import ddr_bank_pkg::*;

  logic cke_ff;
  cmd_e cmd_ff;
  logic [1:0] ba_ff;
  logic [12:0] addr_ff;
  cnt_t hold_ff;
  logic [8:0] read_hold_ff;
  logic [3:0] open_ff;
  logic ready_ff;

  // Long wait only gates READ; other commands run after exit time
  wire hold_busy = (hold_ff != 8'h00);
  wire read_blk = (read_hold_ff != 9'h000) && req_cmd == CMD_READ;
  wire needs_idle = (req_cmd == CMD_REF || req_cmd == CMD_SREF)
    && (open_ff != 4'h0);
  wire go = req_valid && ready_ff && !read_blk && !needs_idle;
  wire drop_cke = !req_cke && (hold_ff == 8'h00);
  wire in_sref = (cmd_ff == CMD_SREF) && !cke_ff;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cke_ff <= 1'b1;
      cmd_ff <= CMD_NOP;
      ba_ff <= 2'h0;
      addr_ff <= 13'h0000;
      hold_ff <= 8'h00;
      read_hold_ff <= 9'h000;
      open_ff <= 4'h0;
      ready_ff <= 1'b0;
    end else begin
      // One idle cycle after each accepted command lets a new hold land
      ready_ff <= !hold_busy && cke_ff && req_cke && !(go && cke_ff);
      hold_ff <= hold_busy ? hold_ff - 8'h01 : 8'h00;
      if (read_hold_ff != 9'h000)
        read_hold_ff <= read_hold_ff - 9'h001;
      if (in_sref) begin
        cke_ff <= req_cke;
        if (req_cke) begin
          hold_ff <= cnt_t'(`XSNR_CYC);
          read_hold_ff <= 9'(`XSRD_CYC);
        end
      end else begin
        cke_ff <= !drop_cke;
        if (go && cke_ff) begin
          cmd_ff <= req_cmd;
          ba_ff <= req_ba;
          addr_ff <= req_addr;
          case (req_cmd)
            CMD_ACT: open_ff[req_ba] <= 1'b1;
            CMD_PRE: begin
              if (req_addr[`A10_BIT])
                open_ff <= 4'h0;
              else
                open_ff[req_ba] <= 1'b0;
              hold_ff <= cnt_t'(`RP_CYC);
            end
            CMD_READ, CMD_WRITE: begin
              if (req_addr[`A10_BIT]) begin
                open_ff[req_ba] <= 1'b0;
                hold_ff <= cnt_t'(`RAS_CYC + `RP_CYC);
              end else begin
                hold_ff <= cnt_t'(`BURST_CYC);
              end
            end
            CMD_REF: hold_ff <= cnt_t'(`RFC_CYC);
            CMD_EMRS_DLL: read_hold_ff <= 9'(`XSRD_CYC);
            CMD_SREF: cke_ff <= 1'b0;
            default: begin
            end
          endcase
        end else begin
          cmd_ff <= (cmd_ff == CMD_SREF && !cke_ff) ? CMD_SREF : CMD_NOP;
        end
      end
    end
  end

  assign link.cke = cke_ff;
  assign link.cmd = cmd_ff;
  assign link.ba = ba_ff;
  assign link.addr = addr_ff;
  assign req_ready = ready_ff;
endmodule

// File: sim/ddr_link_properties.sv
`timescale 1ns/1ps
`include "ddr_bank_defs.svh"
module ddr_link_checker (
  // Clock and reset
  input logic clock,
  input logic rst_n,
  // Link
  input logic cke,
  input ddr_bank_pkg::cmd_e cmd,
  input logic [1:0] ba,
  input logic [12:0] addr,
  // Device status
  input logic [7:0] bank_state,
  input ddr_bank_pkg::dev_e dev_state,
  input logic dll_on,
  input logic buffers_on,
  input logic [12:0] refresh_row
);
  import ddr_bank_pkg::*;
  localparam int rp_max = `RP_CYC + 1;
  localparam int ap_max = `RAS_CYC + `BURST_CYC + 3;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [1:0] ba_ff;
  logic [12:0] row_ff;
  // Bank of last cycle's command, so the check follows that bank only
  always_ff @(posedge clock) begin
    ba_ff <= ba;
    row_ff <= refresh_row;
  end
  wire [1:0] sel_bank = bank_state[{ba, 1'b0} +: 2];
  wire [1:0] prev_bank = bank_state[{ba_ff, 1'b0} +: 2];
  wire any_act = bank_state[0] | bank_state[2] | bank_state[4]
    | bank_state[6];
  wire live = cke && dev_state == DEV_NORMAL;
  wire in_pd = dev_state == DEV_PRE_PD || dev_state == DEV_ACT_PD;
  wire in_sr = dev_state == DEV_SELF_REFRESH;
  sequence pd_held; in_pd ##1 in_pd; endsequence
  sequence sr_held; in_sr ##1 in_sr; endsequence
  AST_ACT_OPENS: assert property (live && cmd == CMD_ACT
    && sel_bank == BANK_IDLE |=> prev_bank == BANK_ACTIVE)
    else $error("activate did not open bank");
  AST_ACT_WAITS: assert property (live && cmd == CMD_ACT
    && sel_bank == BANK_PRECHARGING |=> prev_bank != BANK_ACTIVE)
    else $error("activate during precharge");
  AST_PRE_ONE: assert property (live && cmd == CMD_PRE && !addr[10]
    && sel_bank == BANK_ACTIVE |=> prev_bank == BANK_PRECHARGING)
    else $error("single precharge missed");
  AST_PRE_ALL: assert property (live && cmd == CMD_PRE
    && addr[10] |=> !any_act) else $error("precharge all left row open");
  AST_PRE_NOP: assert property (live && cmd == CMD_PRE && !addr[10]
    && sel_bank == BANK_IDLE |=> prev_bank == BANK_IDLE)
    else $error("precharge of idle bank acted");
  AST_RP_DONE: assert property (bank_state[1:0] == BANK_PRECHARGING
    |-> ##[1:rp_max] bank_state[1:0] == BANK_IDLE)
    else $error("precharge never finished");
  AST_AUTO_PRE: assert property (live && cmd == CMD_READ && addr[10]
    && ba == 2'h3 && sel_bank == BANK_ACTIVE
    |-> ##[1:ap_max] bank_state[7:6] == BANK_PRECHARGING)
    else $error("auto precharge missed");
  AST_REF_ROW: assert property (live && cmd == CMD_REF
    |=> refresh_row != row_ff) else $error("refresh row stuck");
  AST_PD_ENTRY: assert property (dev_state == DEV_NORMAL && !cke
    && cmd == CMD_NOP |=> dev_state
    == ($past(any_act) ? DEV_ACT_PD : DEV_PRE_PD))
    else $error("power-down kind wrong");
  AST_SR_ENTRY: assert property (dev_state == DEV_NORMAL && !cke
    && cmd == CMD_SREF && bank_state == 8'h00 |=> in_sr)
    else $error("self refresh entry missed");
  AST_PD_BUF: assert property (pd_held |-> !buffers_on)
    else $error("buffers on in power-down");
  AST_PD_EXIT: assert property (in_pd && cke && cmd == CMD_NOP
    |=> dev_state == DEV_NORMAL) else $error("power-down exit missed");
  AST_SR_DLL: assert property (sr_held |-> !dll_on)
    else $error("dll on in self refresh");
endmodule

// File: sim/ddr_bank_refresh_powerdown_tb.sv
`timescale 1ns/1ps
module ddr_bank_refresh_powerdown_tb;
  import ddr_bank_pkg::*;
  logic clock, rst_n, req_valid, req_cke, req_ready;
  logic dll_on, buffers_on, cmd_ok;
  cmd_e req_cmd;
  logic [1:0] req_ba;
  logic [12:0] req_addr, refresh_row, row_seen;
  logic [7:0] bank_state;
  dev_e dev_state;
  int failures, checks_done;
  ddr_link_if link();
  ddr_bank_ctrl ddr_bank_ctrl_i (.clock(clock), .rst_n(rst_n),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_ba(req_ba),
    .req_addr(req_addr), .req_cke(req_cke), .req_ready(req_ready),
    .link(link.ctrl));
  ddr_bank_dev ddr_bank_dev_i (.clock(clock), .rst_n(rst_n),
    .link(link.dram), .bank_state(bank_state), .dev_state(dev_state),
    .dll_on(dll_on), .buffers_on(buffers_on), .cmd_ok(cmd_ok),
    .refresh_row(refresh_row));
  ddr_link_checker ddr_link_checker_i (.clock(clock), .rst_n(rst_n),
    .cke(link.cke), .cmd(link.cmd), .ba(link.ba), .addr(link.addr),
    .bank_state(bank_state), .dev_state(dev_state), .dll_on(dll_on),
    .buffers_on(buffers_on), .refresh_row(refresh_row));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task report_and_stop;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task check(input string what, input logic [12:0] exp,
    input logic [12:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Holds the request until ready is seen at an edge, bounded
  task issue(input cmd_e c, input logic [1:0] b, input logic [12:0] a);
    int n;
    n = 0;
    req_cmd <= c;
    req_ba <= b;
    req_addr <= a;
    req_valid <= 1'b1;
    @(posedge clock);
    while (req_ready !== 1'b1 && n < 50) begin
      @(posedge clock);
      n++;
    end
    if (n == 50) begin
      failures++;
      $display("BAD ready exp 1 got 0");
    end
    req_valid <= 1'b0;
    tick(1);
  endtask
  task t_banks;
    issue(CMD_ACT, 2'h1, 13'h0000);
    tick(2);
    check("open", 13'h0004, 13'(bank_state));
    issue(CMD_PRE, 2'h2, 13'h0000);
    tick(2);
    check("idle pre", 13'h0004, 13'(bank_state));
    issue(CMD_PRE, 2'h1, 13'h0000);
    issue(CMD_ACT, 2'h1, 13'h0000);
    tick(3);
    check("reopen", 13'h0004, 13'(bank_state));
    issue(CMD_ACT, 2'h0, 13'h0000);
    issue(CMD_PRE, 2'h2, 13'h0400);
    tick(3);
    check("pre all", 13'h0000, 13'(bank_state));
    $display("done banks");
  endtask
  task t_auto;
    issue(CMD_ACT, 2'h0, 13'h0000);
    issue(CMD_ACT, 2'h3, 13'h0000);
    issue(CMD_READ, 2'h3, 13'h0400);
    issue(CMD_READ, 2'h0, 13'h0000);
    tick(8);
    check("auto pre", 13'h0001, 13'(bank_state));
    issue(CMD_PRE, 2'h0, 13'h0400);
    tick(3);
    $display("done auto");
  endtask
  task t_refresh;
    row_seen = refresh_row;
    issue(CMD_REF, 2'h3, 13'h1fff);
    tick(4);
    check("row moved", 13'h0001, 13'(refresh_row !== row_seen));
    $display("done refresh");
  endtask
  task t_pd(input logic [1:0] b, input dev_e kind);
    if (kind == DEV_ACT_PD) issue(CMD_ACT, b, 13'h0000);
    req_cke <= 1'b0;
    tick(4);
    check("pd kind", 13'(kind), 13'(dev_state));
    check("buffers", 13'h0000, 13'(buffers_on));
    check("cmd_ok pd", 13'h0000, 13'(cmd_ok));
    req_cke <= 1'b1;
    tick(4);
    check("pd exit", 13'(DEV_NORMAL), 13'(dev_state));
    check("cmd_ok", 13'h0001, 13'(cmd_ok));
    $display("done power-down");
  endtask
  task t_self;
    // CKE must fall right after the entry is taken, so drive it by hand
    req_cmd <= CMD_SREF;
    req_valid <= 1'b1;
    @(posedge clock);
    while (req_ready !== 1'b1) @(posedge clock);
    req_valid <= 1'b0;
    req_cke <= 1'b0;
    tick(4);
    check("sr", 13'(DEV_SELF_REFRESH), 13'(dev_state));
    check("dll off", 13'h0000, 13'(dll_on));
    req_cke <= 1'b1;
    tick(6);
    check("dll on", 13'h0001, 13'(dll_on));
    $display("done self refresh");
  endtask
  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_cmd = CMD_NOP;
    req_ba = 2'h0;
    req_addr = 13'h0000;
    req_cke = 1'b1;
    failures = 0;
    checks_done = 0;
    tick(6);
    rst_n <= 1'b1;
    tick(2);
    t_banks();
    t_auto();
    t_refresh();
    t_pd(2'h0, DEV_PRE_PD);
    t_pd(2'h2, DEV_ACT_PD);
    issue(CMD_PRE, 2'h0, 13'h0400);
    tick(3);
    t_self();
    report_and_stop();
  end
  // Whole run needs well under two hundred cycles; this leaves ample margin
  initial begin
    repeat (3000) @(posedge clock);
    failures++;
    report_and_stop();
  end
endmodule
